/* File: hdl/mibt_consts.svh */
// Constants for the base timer and channel waveform output block
`ifndef MIBT_CONSTS_SVH
`define MIBT_CONSTS_SVH

// Channel output control byte layout
`define MIBT_MODE_LSB 0
`define MIBT_MODE_MSB 2
`define MIBT_IVL_BIT 4
`define MIBT_INV_BIT 5
`define MIBT_TRE_BIT 6
`define MIBT_CTRL_RESET 8'h00

// Channel mode field codes
`define MIBT_MODE_SINGLE 3'h0
`define MIBT_MODE_SR 3'h1
`define MIBT_MODE_DELAY 3'h2
`define MIBT_MODE_UART_RX 3'h6
`define MIBT_MODE_SERIAL 3'h7

// Timer clock select codes
`define MIBT_CLK_STOP 2'h0
`define MIBT_CLK_HALF 2'h1
`define MIBT_CLK_PHASE 2'h2
`define MIBT_CLK_F1 2'h3

// Count direction mode codes
`define MIBT_DIR_UP 2'h0
`define MIBT_DIR_UPDOWN 2'h1
`define MIBT_DIR_PHASE 2'h2

// Divider and counter values
`define MIBT_DIV_BYPASS 5'h1F
`define MIBT_COUNT_ZERO 16'h0000
`define MIBT_COUNT_MAX 16'hFFFF

`endif

/* File: hdl/mibt_pkg.sv */
// Types for the base timer and channel waveform output block
package mibt_pkg;
   typedef enum logic {MIBT_PH_UP, MIBT_PH_DOWN} mibt_phase_t;
endpackage

/* File: hdl/mibt_divider.sv */
// Count source divider: one pulse per 2(n+1) source pulses; n of 31 passes every source pulse
`timescale 1ns/1ps
`default_nettype none
`include "mibt_consts.svh"
module mibt_divider (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Control
   input wire logic clear,
   input wire logic [4:0] div_n,
   // Source and result
   input wire logic src_pulse,
   output logic div_pulse
);
   import mibt_pkg::*;
   logic [4:0] cnt;
   logic half;
   wire bypass = (div_n == `MIBT_DIV_BYPASS);
   wire wrap = src_pulse && (cnt == div_n);
   wire [4:0] next_cnt = clear ? 5'h00 : wrap ? 5'h00 :
                         src_pulse ? cnt + 5'h01 : cnt;
   wire next_half = clear ? 1'b0 : wrap ? ~half : half;
   // Pulse on the falling half so a period spans 2(n+1) source pulses
   wire next_pulse = !clear && (bypass ? src_pulse : (wrap && half));

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= 5'h00;
         half <= 1'b0;
         div_pulse <= 1'b0;
      end else begin
         cnt <= next_cnt;
         half <= next_half;
         div_pulse <= next_pulse;
      end
   end
endmodule
`default_nettype wire

/* File: hdl/mibt_chan_out.sv */
// One channel's waveform level, serial routing and output inversion
`timescale 1ns/1ps
`default_nettype none
`include "mibt_consts.svh"
module mibt_chan_out #(
   parameter int IDX = 0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Configuration
   input wire logic [7:0] ctrl,
   input wire logic func_sel,
   input wire logic func_en,
   input wire logic sr_silent,
   // Events and serial data
   input wire logic match_evt,
   input wire logic partner_evt,
   input wire logic clear_evt,
   input wire logic tx_data,
   input wire logic sclk_data,
   // Pin
   output logic pin_out,
   output logic pin_oe
);
   import mibt_pkg::*;
   initial begin
      if (IDX < 0 || IDX > 7) $error("mibt_chan_out: IDX out of range");
   end
   localparam bit IS_EVEN = (IDX % 2) == 0;
   logic level;
   logic ivl_q;
   wire [2:0] mode = ctrl[`MIBT_MODE_MSB:`MIBT_MODE_LSB];
   wire initial_level = ctrl[`MIBT_IVL_BIT];
   wire output_invert = ctrl[`MIBT_INV_BIT];
   wire wave_on = !func_sel && func_en;
   wire ivl_wr = initial_level != ivl_q;
   // SR is only honoured on an even channel
   wire sr_ok = (mode == `MIBT_MODE_SR) && IS_EVEN;
   wire wave_mode = (mode == `MIBT_MODE_SINGLE) ||
                    (mode == `MIBT_MODE_DELAY) || sr_ok;
   // Serial routing exists only on channels 0 and 1
   wire route_ok = (mode == `MIBT_MODE_SERIAL) && (IDX < 2);
   wire serial_bit = (IDX == 0) ? tx_data : sclk_data;
   logic next_level;
   always_comb begin
      next_level = level;
      if (!wave_on || ivl_wr) begin
         next_level = initial_level;
      end else begin
         case (mode)
            `MIBT_MODE_SINGLE: begin
               if (match_evt) next_level = 1'b1;
               else if (clear_evt) next_level = 1'b0;
            end
            `MIBT_MODE_SR: begin
               if (sr_ok && match_evt) next_level = 1'b1;
               else if (sr_ok && partner_evt) next_level = 1'b0;
            end
            `MIBT_MODE_DELAY: begin
               if (match_evt) next_level = ~level;
            end
            default: next_level = level;
         endcase
      end
   end
   // Inversion follows the waveform level; serial routing bypasses it
   wire next_out = route_ok ? serial_bit : (level ^ output_invert);
   // UART receive leaves the pin undriven; odd SR partner is silent
   wire next_oe = route_ok ||
                  (wave_on && wave_mode && !sr_silent);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         level <= 1'b0;
         ivl_q <= 1'b0;
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end else begin
         level <= next_level;
         ivl_q <= initial_level;
         pin_out <= next_out;
         pin_oe <= next_oe;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence s_ivl_forced;
      wave_on && ivl_wr && !route_ok;
   endsequence
   sequence s_quiet;
      $stable(ctrl) && !match_evt && !partner_evt && !clear_evt;
   endsequence
   AST_INV_DEFAULT: assert property (
      s_ivl_forced ##1 s_quiet |=> pin_out == $past(initial_level ^ output_invert))
      else $error("default level not inverted initial level");
   AST_SERIAL_ROUTE: assert property (
      route_ok |=> pin_oe && pin_out == $past(serial_bit))
      else $error("serial route not followed");
   AST_SR_SILENT: assert property (
      sr_silent && !route_ok |=> !pin_oe)
      else $error("odd SR partner drives the pin");
   AST_UART_IDLE: assert property (
      mode == `MIBT_MODE_UART_RX |=> !pin_oe)
      else $error("UART receive channel drives the pin");
endmodule
`default_nettype wire

/* File: hdl/mibt_top.sv */
// Base timer and eight channel waveform output stages
// Notes on behaviour
// - SR mode on even channels; odd ignored
// - Mode 111 routes serial pins, channels 0/1
// - Timer reset enable only in channel 0
// - Inversion is the final waveform stage
// - Inverted: default high if initial level zero
// - Count source is source over 2(n+1)
// - n of 31 passes source undivided
// - Free-running counter on internal count source
// - Increment, up/down, two-phase counting operations
// - Run bit one starts counting
// - Run bit zero stops and resets timer
// - Run bit zero holds timer at zero
// - Direction codes: 00 up, 01 up/down, 10 two-phase
`timescale 1ns/1ps
`default_nettype none
`include "mibt_consts.svh"
module mibt_top #(
   parameter int CHANNELS = 8
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic ARST_N,
   // Base timer control
   input wire logic TIMER_RUN_BIT,
   input wire logic [1:0] TIMER_CLOCK_SELECT,
   input wire logic [4:0] DIVIDER_FIELD,
   input wire logic [1:0] COUNT_DIRECTION_MODE,
   input wire logic [15:0] RESET_COMPARE_VALUE,
   // Two-phase pulse pins
   input wire logic PHASE_A_PIN,
   input wire logic PHASE_B_PIN,
   // Channel control, one byte per channel
   input wire logic [8*CHANNELS-1:0] CHAN_OUTPUT_CTRL,
   input wire logic [CHANNELS-1:0] FUNC_SELECT_CHAN,
   input wire logic [CHANNELS-1:0] CHAN_FUNC_ENABLE,
   input wire logic [CHANNELS-1:0] CHAN_MATCH_EVT,
   // Serial engine data
   input wire logic SERIAL_TX_DATA,
   input wire logic SERIAL_CLOCK_DATA,
   // Base timer state
   output logic [15:0] TIMER_COUNT,
   output logic TIMER_COUNT_SOURCE,
   output var mibt_pkg::mibt_phase_t TIMER_PHASE,
   // Channel pins
   output logic [CHANNELS-1:0] CHAN_OUT,
   output logic [CHANNELS-1:0] CHAN_OE
);
   import mibt_pkg::*;
   initial begin
      if (CHANNELS != 8) $error("mibt_top: eight channels only");
   end

   // Pin synchronisers; only the second stage is read
   logic [1:0] sync_a;
   logic [1:0] sync_b;
   logic prev_a;
   logic prev_b;
   logic half_tgl;
   logic qd_up;
   logic [1:0] rst_pipe;
   logic run_q;

   wire cur_a = sync_a[1];
   wire cur_b = sync_b[1];
   // One input changed: a legal quadrature step
   wire qd_evt = (cur_a ^ prev_a) ^ (cur_b ^ prev_b);
   wire qd_dir = prev_a ^ cur_b;
   wire next_qd_up = qd_evt ? qd_dir : qd_up;

   // Count source selection
   wire sel_f1 = (TIMER_CLOCK_SELECT == `MIBT_CLK_F1);
   wire sel_half = (TIMER_CLOCK_SELECT == `MIBT_CLK_HALF);
   wire sel_phase = (TIMER_CLOCK_SELECT == `MIBT_CLK_PHASE);
   wire src_pulse = sel_f1 ? 1'b1 :
                    sel_half ? half_tgl :
                    sel_phase ? qd_evt : 1'b0;
   wire div_clear = !TIMER_RUN_BIT;
   wire count_evt;

   mibt_divider u_div (
      .clk(CORE_CLK),
      .arst_n(ARST_N),
      .clear(div_clear),
      .div_n(DIVIDER_FIELD),
      .src_pulse(src_pulse),
      .div_pulse(count_evt)
   );

   // Timer reset on compare match, channel 0's enable only
   wire tre = CHAN_OUTPUT_CTRL[`MIBT_TRE_BIT];
   wire dir_up = (COUNT_DIRECTION_MODE == `MIBT_DIR_UP);
   wire dir_ud = (COUNT_DIRECTION_MODE == `MIBT_DIR_UPDOWN);
   wire dir_ph = (COUNT_DIRECTION_MODE == `MIBT_DIR_PHASE);
   wire hit = tre && (TIMER_COUNT == RESET_COMPARE_VALUE);
   // Two count events after the match the timer clears
   wire [1:0] next_rst_pipe = !TIMER_RUN_BIT ? 2'b00 :
                              count_evt ? {rst_pipe[0], hit} : rst_pipe;
   // Relies on software picking f1 here; increment mode is checked by dir_up
   wire do_reset = count_evt && rst_pipe[1] && dir_up;
   // Two-phase counting down never takes the match reset
   wire ph_reset = count_evt && rst_pipe[1] && dir_ph && qd_up;
   wire ud_turn = count_evt && rst_pipe[1] && dir_ud;
   // Code 11 has no counting operation, so the counter must hold
   wire dir_none = !dir_up && !dir_ud && !dir_ph;

   wire at_max = (TIMER_COUNT == `MIBT_COUNT_MAX);
   wire at_zero = (TIMER_COUNT == `MIBT_COUNT_ZERO);
   wire [15:0] count_inc = TIMER_COUNT + 16'h0001;
   wire [15:0] count_dec = TIMER_COUNT - 16'h0001;

   logic [15:0] next_count;
   mibt_phase_t next_phase;
   always_comb begin
      next_count = TIMER_COUNT;
      next_phase = TIMER_PHASE;
      if (!TIMER_RUN_BIT) begin
         next_count = `MIBT_COUNT_ZERO;
         next_phase = MIBT_PH_UP;
      end else if (do_reset || ph_reset) begin
         next_count = `MIBT_COUNT_ZERO;
      end else if (count_evt) begin
         case (COUNT_DIRECTION_MODE)
            `MIBT_DIR_UP: begin
               next_count = count_inc;
            end
            `MIBT_DIR_UPDOWN: begin
               case (TIMER_PHASE)
                  MIBT_PH_UP: begin
                     if (at_max || ud_turn) begin
                        next_count = count_dec;
                        next_phase = MIBT_PH_DOWN;
                     end else begin
                        next_count = count_inc;
                     end
                  end
                  MIBT_PH_DOWN: begin
                     if (at_zero) begin
                        next_count = count_inc;
                        next_phase = MIBT_PH_UP;
                     end else begin
                        next_count = count_dec;
                     end
                  end
                  default: next_phase = MIBT_PH_UP;
               endcase
            end
            `MIBT_DIR_PHASE: begin
               next_count = qd_up ? count_inc : count_dec;
            end
            default: next_count = TIMER_COUNT;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sync_a <= 2'b00;
         sync_b <= 2'b00;
         prev_a <= 1'b0;
         prev_b <= 1'b0;
         qd_up <= 1'b1;
      end else begin
         sync_a <= {sync_a[0], PHASE_A_PIN};
         sync_b <= {sync_b[0], PHASE_B_PIN};
         prev_a <= cur_a;
         prev_b <= cur_b;
         qd_up <= next_qd_up;
      end
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         half_tgl <= 1'b0;
         rst_pipe <= 2'b00;
         run_q <= 1'b0;
         TIMER_COUNT <= `MIBT_COUNT_ZERO;
         TIMER_PHASE <= MIBT_PH_UP;
         TIMER_COUNT_SOURCE <= 1'b0;
      end else begin
         half_tgl <= ~half_tgl;
         rst_pipe <= next_rst_pipe;
         run_q <= TIMER_RUN_BIT;
         TIMER_COUNT <= next_count;
         TIMER_PHASE <= next_phase;
         TIMER_COUNT_SOURCE <= count_evt;
      end
   end

   // Per-channel output stages
   wire clear_evt = do_reset || (count_evt && dir_up && at_max);
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g = g + 1) begin : g_chan
         localparam int PART = (g % 2 == 0) ? g + 1 : g - 1;
         wire [7:0] ctrl_g = CHAN_OUTPUT_CTRL[8*g +: 8];
         wire [7:0] ctrl_p = CHAN_OUTPUT_CTRL[8*PART +: 8];
         // Odd channel goes quiet while its even partner runs SR
         wire silent = (g % 2 == 1) &&
            (ctrl_p[`MIBT_MODE_MSB:`MIBT_MODE_LSB] == `MIBT_MODE_SR);
         mibt_chan_out #(.IDX(g)) u_chan (
            .clk(CORE_CLK),
            .arst_n(ARST_N),
            .ctrl(ctrl_g),
            .func_sel(FUNC_SELECT_CHAN[g]),
            .func_en(CHAN_FUNC_ENABLE[g]),
            .sr_silent(silent),
            .match_evt(CHAN_MATCH_EVT[g]),
            .partner_evt(CHAN_MATCH_EVT[PART]),
            .clear_evt(clear_evt),
            .tx_data(SERIAL_TX_DATA),
            .sclk_data(SERIAL_CLOCK_DATA),
            .pin_out(CHAN_OUT[g]),
            .pin_oe(CHAN_OE[g])
         );
      end
   endgenerate

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!ARST_N);

   sequence s_stopped;
      !TIMER_RUN_BIT;
   endsequence
   sequence s_first_step;
      TIMER_RUN_BIT && count_evt && dir_up && !rst_pipe[1];
   endsequence
   sequence s_ud_bottom;
      TIMER_RUN_BIT && dir_ud && count_evt && at_zero &&
      TIMER_PHASE == MIBT_PH_DOWN;
   endsequence
   sequence s_phase_up_step;
      TIMER_RUN_BIT && dir_ph && count_evt && qd_up && !rst_pipe[1];
   endsequence

   AST_STOP_ZERO: assert property (
      s_stopped |=> TIMER_COUNT == `MIBT_COUNT_ZERO)
      else $error("stopped timer not held at zero");
   AST_STOP_NO_SOURCE: assert property (
      s_stopped ##1 s_stopped |-> !count_evt)
      else $error("count source runs while stopped");
   AST_START_STEP: assert property (
      !run_q ##1 s_first_step |=> TIMER_COUNT == 16'h0001)
      else $error("first count after start is not one");
   AST_INC_ONE: assert property (
      s_first_step |=> TIMER_COUNT == $past(TIMER_COUNT) + 16'h0001)
      else $error("increment mode step is not one");
   AST_HOLD_IDLE: assert property (
      TIMER_RUN_BIT && !count_evt |=> $stable(TIMER_COUNT))
      else $error("counter moved without a count event");
   AST_BYPASS: assert property (
      TIMER_RUN_BIT && sel_f1 && DIVIDER_FIELD == `MIBT_DIV_BYPASS
      ##1 TIMER_RUN_BIT && $stable(DIVIDER_FIELD) && sel_f1
      |=> count_evt)
      else $error("n of 31 does not pass the source through");
   AST_DIV_PERIOD: assert property (
      (TIMER_RUN_BIT && sel_f1 && DIVIDER_FIELD == 5'h00 && count_evt)
      [*1] ##1 (TIMER_RUN_BIT && $stable(DIVIDER_FIELD) && sel_f1) [*2]
      |-> !$past(count_evt) && count_evt)
      else $error("divide by two period wrong");
   AST_UD_TURN: assert property (
      TIMER_RUN_BIT && dir_ud && count_evt && at_max &&
      TIMER_PHASE == MIBT_PH_UP
      |=> TIMER_COUNT == 16'hFFFE && TIMER_PHASE == MIBT_PH_DOWN)
      else $error("up/down did not turn at the top");
   AST_DIR_PHASE: assert property (
      TIMER_RUN_BIT && dir_ph && count_evt && !qd_up
      |=> TIMER_COUNT == $past(TIMER_COUNT) - 16'h0001)
      else $error("two-phase down step wrong");
   AST_TRE_CLEAR: assert property (
      TIMER_RUN_BIT && dir_up && count_evt && rst_pipe[1]
      |=> TIMER_COUNT == `MIBT_COUNT_ZERO)
      else $error("match reset did not clear the timer");

   // Paths the bench reaches seldom or never
   AST_STOP_PHASE: assert property (
      s_stopped |=> TIMER_PHASE == MIBT_PH_UP)
      else $error("stopped timer not back in up phase");
   AST_STOP_PIPE: assert property (
      s_stopped |=> rst_pipe == 2'b00)
      else $error("stopped timer kept a pending match reset");
   AST_UD_BOTTOM: assert property (
      s_ud_bottom |=> TIMER_COUNT == 16'h0001 &&
      TIMER_PHASE == MIBT_PH_UP)
      else $error("up/down did not turn at the bottom");
   AST_PH_UP_STEP: assert property (
      s_phase_up_step |=> TIMER_COUNT == $past(TIMER_COUNT) + 16'h0001)
      else $error("two-phase up step wrong");
   AST_PH_BYPASS: assert property (
      TIMER_RUN_BIT && sel_phase && qd_evt &&
      DIVIDER_FIELD == `MIBT_DIV_BYPASS |=> count_evt)
      else $error("undivided two-phase step lost");
   // Only channel 0 may arm the match reset; other bit 6 copies are inert
   AST_TRE_CH0_ONLY: assert property (
      !CHAN_OUTPUT_CTRL[`MIBT_TRE_BIT] && !rst_pipe[0] |=> !rst_pipe[0])
      else $error("match reset armed without channel 0 enable");
   AST_DIR_HOLD: assert property (
      TIMER_RUN_BIT && dir_none |=> $stable(TIMER_COUNT))
      else $error("direction code 11 moved the counter");
endmodule
`default_nettype wire

/* File: verif/mibt_top_tb.sv */
// Self-checking bench for the base timer and channel output block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] %0t got %h expected %h", $time, g, e); end end
module mibt_top_tb;
   import mibt_pkg::*;
   logic core_clk, arst_n, run, ph_a, ph_b, txd, sckd;
   logic [1:0] csel, dmode;
   logic [4:0] divn;
   logic [15:0] cmpv, timer_count, mg, me, mx;
   logic [63:0] ctrl;
   logic [7:0] fsel, fen, mevt, chan_out, chan_oe, rv, iv, ev;
   logic tcs, arm, have_prev, flag, wrapped;
   mibt_phase_t timer_phase;
   int n_errors, cmp_count, cyc_n, t_prev, mk, w, pk;
   int q_k[$];
   logic [15:0] q_e[$];
   int q_p[$];
   logic [1:0] qtab [4] = '{2'h0, 2'h1, 2'h3, 2'h2};

   mibt_top DUT (.CORE_CLK(core_clk), .ARST_N(arst_n),
      .TIMER_RUN_BIT(run), .TIMER_CLOCK_SELECT(csel), .DIVIDER_FIELD(divn),
      .COUNT_DIRECTION_MODE(dmode), .RESET_COMPARE_VALUE(cmpv),
      .PHASE_A_PIN(ph_a), .PHASE_B_PIN(ph_b), .CHAN_OUTPUT_CTRL(ctrl),
      .FUNC_SELECT_CHAN(fsel), .CHAN_FUNC_ENABLE(fen),
      .CHAN_MATCH_EVT(mevt), .SERIAL_TX_DATA(txd),
      .SERIAL_CLOCK_DATA(sckd), .TIMER_COUNT(timer_count),
      .TIMER_COUNT_SOURCE(tcs), .TIMER_PHASE(timer_phase),
      .CHAN_OUT(chan_out), .CHAN_OE(chan_oe));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk) cyc_n++;

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Note an expectation; the monitor compares at the next falling edge
   task automatic note(input int k, input logic [15:0] e);
      q_k.push_back(k);
      q_e.push_back(e);
      @(negedge core_clk);
      @(posedge core_clk);
   endtask
   task automatic set_chan(input int j, input logic [7:0] b);
      ctrl[8*j +: 8] <= b;
   endtask
   task automatic tally_and_finish;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Static result monitor
   always @(negedge core_clk) begin
      while (q_k.size() > 0) begin
         mk = q_k.pop_front();
         me = q_e.pop_front();
         case (mk)
            0: mg = timer_count;
            1: mg = {8'h00, chan_out};
            2: mg = {8'h00, chan_oe};
            3: mg = {15'h0000, timer_phase};
            4: mg = {15'h0000, flag};
            5: mg = {14'h0000, chan_out[1:0]};
            7: mg = {15'h0000, chan_out[4]};
            default: mg = {15'h0000, chan_out[0]};
         endcase
         `CHK(mg, me)
      end
   end
   // Count source pulse monitor: spacing and step size
   always @(negedge core_clk) begin
      if (!arm)
         have_prev = 1'b0;
      else if (tcs === 1'b1) begin
         if (have_prev && q_p.size() > 0) begin
            pk = q_p.pop_front();
            `CHK(cyc_n - t_prev, pk)
            `CHK(timer_count, mx + 16'h0001)
         end else if (!have_prev)
            `CHK(timer_count, 16'h0001)
         have_prev = 1'b1;
         t_prev = cyc_n;
         mx = timer_count;
      end
   end

   task automatic per_case(input logic [1:0] s, input logic [4:0] n);
      int p;
      run <= 1'b0;
      cyc(3);
      note(0, 16'h0000);
      csel <= s;
      divn <= n;
      dmode <= 2'h0;
      cyc(2);
      p = (n == 5'h1F) ? 1 : 2 * (n + 1);
      if (s == 2'h1)
         p = p * 2;
      repeat (4) q_p.push_back(p);
      run <= 1'b1;
      arm <= 1'b1;
      w = 0;
      while (q_p.size() > 0 && w < 400) begin
         cyc(1);
         w++;
      end
      `CHK(q_p.size(), 0)
      arm <= 1'b0;
      run <= 1'b0;
      cyc(2);
   endtask

   initial begin
      arst_n = 1'b0; run = 1'b0; ph_a = 1'b0; ph_b = 1'b0; txd = 1'b0;
      sckd = 1'b0; csel = 2'h3; dmode = 2'h0; divn = 5'h1F; cmpv = 16'h0004;
      ctrl = 64'h0; fsel = 8'h00; fen = 8'h00; mevt = 8'h00; arm = 1'b0;
      n_errors = 0; cmp_count = 0; cyc_n = 0; flag = 1'b0;
      void'($urandom(32'h5FBF4F6E));
      cyc(6);
      arst_n <= 1'b1;
      cyc(2);
      // Divider ratios for both internal sources
      per_case(2'h3, 5'h00);
      per_case(2'h3, 5'h1F);
      per_case(2'h3, 5'($urandom_range(1, 6)));
      per_case(2'h1, 5'h00);
      per_case(2'h1, 5'h1F);
      per_case(2'h1, 5'($urandom_range(1, 6)));
      // Reset enable on channel 1 must not limit the count
      set_chan(1, 8'h40);
      csel <= 2'h3;
      divn <= 5'h1F;
      run <= 1'b1;
      w = 0;
      while (timer_count !== 16'd10 && w < 40) begin
         @(negedge core_clk);
         w++;
      end
      @(posedge core_clk);
      flag = (w < 40);
      note(4, 16'h0001);
      run <= 1'b0;
      set_chan(1, 8'h00);
      set_chan(0, 8'h40);
      cyc(3);
      run <= 1'b1;
      mx = 16'h0000;
      wrapped = 1'b0;
      repeat (40) begin
         @(negedge core_clk);
         if (timer_count > mx)
            mx = timer_count;
         if (mx != 16'h0000 && timer_count === 16'h0000)
            wrapped = 1'b1;
      end
      @(posedge core_clk);
      flag = wrapped && (mx == cmpv + 16'h0002);
      note(4, 16'h0001);
      run <= 1'b0;
      set_chan(0, 8'h00);
      // Up/down turnaround at the top of the range
      dmode <= 2'h1;
      cyc(3);
      run <= 1'b1;
      w = 0;
      while (timer_count !== 16'hFFFF && w < 70000) begin
         @(negedge core_clk);
         w++;
      end
      cyc(3);
      note(0, 16'hFFFC);
      note(3, 16'h0001);
      run <= 1'b0;
      // Two-phase: eight steps forward, three back
      csel <= 2'h2;
      dmode <= 2'h2;
      cyc(4);
      run <= 1'b1;
      cyc(4);
      for (int i = 1; i <= 8; i++) begin
         {ph_a, ph_b} <= qtab[i % 4];
         cyc(4);
      end
      for (int i = 3; i >= 1; i--) begin
         {ph_a, ph_b} <= qtab[i];
         cyc(4);
      end
      cyc(4);
      note(0, 16'h0005);
      run <= 1'b0;
      // Default levels with inversion; function chosen before level
      repeat (4) begin
         rv = 8'($urandom);
         iv = 8'($urandom);
         ev = 8'($urandom);
         fsel <= 8'($urandom);
         fen <= ev;
         cyc(1);
         for (int j = 0; j < 8; j++)
            set_chan(j, {2'b00, iv[j], rv[j], 4'h0});
         cyc(4);
         note(1, {8'h00, rv ^ iv});
         note(2, {8'h00, ev & ~fsel});
      end
      // Serial routing, never inverted
      fsel <= 8'h00;
      fen <= 8'hFF;
      for (int j = 0; j < 8; j++)
         set_chan(j, j == 0 ? 8'h27 : 8'h07);
      repeat (4) begin
         txd <= 1'($urandom);
         sckd <= 1'($urandom);
         cyc(3);
         note(5, {14'h0000, sckd, txd});
         note(2, 16'h0003);
      end
      // SR pair on 0/1 and receive pattern on channel 2
      for (int j = 0; j < 8; j++)
         set_chan(j, 8'h00);
      set_chan(0, 8'h01);
      set_chan(2, 8'h06);
      cyc(4);
      note(2, 16'h00F9);
      mevt <= 8'h01;
      cyc(1);
      mevt <= 8'h00;
      cyc(3);
      note(6, 16'h0001);
      mevt <= 8'h02;
      cyc(1);
      mevt <= 8'h00;
      cyc(3);
      note(6, 16'h0000);
      note(2, 16'h00F9);
      // Toggle mode on channel 4, inverted after the toggle
      set_chan(4, 8'h22);
      for (int i = 0; i < 2; i++) begin
         cyc(3);
         mevt <= 8'h10;
         cyc(1);
         mevt <= 8'h00;
         cyc(3);
         note(7, 16'(i));
      end
      cyc(2);
      tally_and_finish();
   end

   // Hang guard, well above the expected run length
   initial begin
      repeat (90000) @(posedge core_clk);
      n_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule
`undef CHK
`default_nettype wire
